// >>> hw/smbcs_consts.svh
// named constants of the serial bus control/status register block
// assumes inclusion by bare name from every file that needs them
`ifndef SMBCS_CONSTS_SVH
`define SMBCS_CONSTS_SVH

// special-function address and page of the control/status register
`define SMBCS_CTRL_ADDR 8'hC0
`define SMBCS_CTRL_PAGE 8'h00
// upper five bits of the bit addresses that reach the register
`define SMBCS_BIT_BASE 5'h18
// value of every bit after reset
`define SMBCS_RESET_VAL 8'h00
// bit positions inside the register
`define SMBCS_BIT_ROLE 3'h7
`define SMBCS_BIT_TXDIR 3'h6
`define SMBCS_BIT_STARTREQ 3'h5
`define SMBCS_BIT_STOPREQ 3'h4
`define SMBCS_BIT_ACKNEED 3'h3
`define SMBCS_BIT_ARBLOSS 3'h2
`define SMBCS_BIT_ACK 3'h1
`define SMBCS_BIT_EVENT 3'h0
// widths of the pin synchronisers
`define SMBCS_LINK_SYNC_W 2
`define SMBCS_CORE_SYNC_W 4

`endif

// >>> hw/smbcs_ctrl.sv
// control/status register of the two-wire serial bus interface
// assumes a byte-engine on clk_in reporting bus events as one-cycle pulses,
// and an 8-bit special-function bus with byte and bit writes
//
// Contract
// - bit 7 reads controller role
// - role set on start, cleared stop/arbitration
// - start request bit initiates start
// - received start+address sets start request
// - stop request sent, then cleared
// - detected stop sets stop request when addressed or on arbitration loss
// - ack needed after received byte
// - unwanted repeated start loses arbitration
// - clock low during condition loses arbitration
// - data low while sending one loses
// - arbitration flag clears with event flag
// - bit 1 shows received ack
// - bit 1 write selects sent ack
// - bus events set event flag
// - event flag holds clock low
// - software clears or forces event flag
// - register at 0xC0 page 0, bit-addressable
// - unwritten ack bit sends nack
// - stop and start give stop first
// - automatic ack sends ack bit
`timescale 1ns/1ps
`default_nettype none
`include "smbcs_consts.svh"

module smbcs_ctrl
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic link_clk_in,
  // special-function bus
  input wire logic [7:0] sfr_page_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_bit_wr_in,
  input wire logic [7:0] sfr_bit_addr_in,
  input wire logic sfr_bit_val_in,
  output logic [7:0] sfr_rdata_out,
  // bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // byte-engine events
  input wire logic eng_start_gen_in,
  input wire logic eng_stop_gen_in,
  input wire logic eng_byte_tx_in,
  input wire logic eng_ack_value_in,
  input wire logic eng_byte_rx_in,
  input wire logic eng_addr_rx_in,
  input wire logic eng_addressed_in,
  input wire logic eng_ack_slot_in,
  input wire logic eng_ack_done_in,
  input wire logic eng_tx_bit_in,
  input wire logic eng_tx_level_in,
  input wire logic eng_tx_is_ack_in,
  input wire logic eng_gen_cond_in,
  input wire logic eng_frame_start_in,
  input wire logic data_written_in,
  input wire logic auto_address_response_enable_in,
  // requests to the byte engine
  output logic gen_start_out,
  output logic gen_stop_out,
  output logic next_event_out,
  output logic controller_role_out,
  output logic transmit_direction_out
);

  // register bits
  logic controller_role_flag;
  logic transmit_direction_flag;
  logic start_request_flag;
  logic stop_request_flag;
  logic ack_needed_flag;
  logic arbitration_loss_flag;
  logic ack_value;
  logic event_pending_flag;
  // bookkeeping
  logic ack_written;
  logic data_since_frame;
  logic start_seen;
  logic stop_seen;
  smbcs_pkg::smbcs_byte_t rdata;
  // next values
  logic next_controller_role_flag;
  logic next_transmit_direction_flag;
  logic next_start_request_flag;
  logic next_stop_request_flag;
  logic next_ack_needed_flag;
  logic next_arbitration_loss_flag;
  logic next_ack_value;
  logic next_event_pending_flag;
  logic next_ack_written;
  logic next_data_since_frame;
  logic next_start_seen;
  logic next_stop_seen;
  smbcs_pkg::smbcs_byte_t next_rdata;
  // decoded terms
  logic [`SMBCS_CORE_SYNC_W-1:0] synced;
  logic start_tgl;
  logic stop_tgl;
  logic start_det;
  logic stop_det;
  logic scl_s;
  logic sda_s;
  logic byte_wr;
  logic bit_wr;
  logic arb_rs;
  logic arb_scl;
  logic arb_sda;
  logic arb_stop;
  logic arb_ev;
  logic si_set;
  logic si_clear_ev;
  logic wr_start;
  logic wr_stop;
  logic wr_ack;
  logic wr_event;
  smbcs_pkg::smbcs_byte_t reg_view;

  ////////////////////////////////////////////////////////////////////////
  // is a register bit hit by this cycle's byte or bit write
  function automatic logic bit_sel(input logic bw, input logic tw,
    input logic [2:0] baddr, input smbcs_pkg::smbcs_bit_idx_t idx);
    bit_sel = bw | (tw & (baddr == idx));
  endfunction

  // value written to a register bit by a byte or a bit write
  function automatic logic bit_val(input logic bw, input logic [7:0] wd,
    input logic tv, input smbcs_pkg::smbcs_bit_idx_t idx);
    bit_val = bw ? wd[idx] : tv;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // link-side condition detector in its own clock domain
  smbcs_link_det u_link
  (
    .link_clk_in(link_clk_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .start_tgl_out(start_tgl),
    .stop_tgl_out(stop_tgl)
  );

  // pins and link toggles cross into clk_in through two flops each
  smbcs_sync #(.W(`SMBCS_CORE_SYNC_W)) u_core_sync
  (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .en_in(ce_in),
    .d_in({stop_tgl, start_tgl, scl_in, sda_in}),
    .q_out(synced)
  );

  assign sda_s = synced[0];
  assign scl_s = synced[1];
  // toggle change after synchronisation marks one detected condition
  assign start_det = synced[2] ^ start_seen;
  assign stop_det = synced[3] ^ stop_seen;

  ////////////////////////////////////////////////////////////////////////
  // address decode: one byte address, eight bit addresses, page 0 only
  assign byte_wr = sfr_wr_in & (sfr_addr_in == `SMBCS_CTRL_ADDR) &
    (sfr_page_in == `SMBCS_CTRL_PAGE);
  assign bit_wr = sfr_bit_wr_in & (sfr_bit_addr_in[7:3] == `SMBCS_BIT_BASE) &
    (sfr_page_in == `SMBCS_CTRL_PAGE);
  // only the four read/write bits decode; others drop the write
  assign wr_start = bit_sel(byte_wr, bit_wr, sfr_bit_addr_in[2:0],
    `SMBCS_BIT_STARTREQ);
  assign wr_stop = bit_sel(byte_wr, bit_wr, sfr_bit_addr_in[2:0],
    `SMBCS_BIT_STOPREQ);
  assign wr_ack = bit_sel(byte_wr, bit_wr, sfr_bit_addr_in[2:0],
    `SMBCS_BIT_ACK);
  assign wr_event = bit_sel(byte_wr, bit_wr, sfr_bit_addr_in[2:0],
    `SMBCS_BIT_EVENT);

  ////////////////////////////////////////////////////////////////////////
  // arbitration loss causes
  assign arb_rs = start_det & controller_role_flag &
    !start_request_flag;
  assign arb_scl = eng_gen_cond_in & !scl_s;
  assign arb_sda = eng_tx_bit_in & eng_tx_level_in & !eng_tx_is_ack_in &
    !sda_s;
  // a stop we did not make while holding the bus
  assign arb_stop = stop_det & controller_role_flag & !eng_stop_gen_in;
  assign arb_ev = arb_rs | arb_scl | arb_sda | arb_stop;

  // every hardware source of the event flag
  assign si_set = eng_start_gen_in | arb_ev | eng_byte_tx_in |
    eng_byte_rx_in | eng_addr_rx_in | (stop_det & eng_addressed_in);
  // software write of zero to a set flag releases the engine
  assign si_clear_ev = wr_event & event_pending_flag &
    !bit_val(byte_wr, sfr_wdata_in, sfr_bit_val_in, `SMBCS_BIT_EVENT);

  ////////////////////////////////////////////////////////////////////////
  // next register values; each hardware set except the role's is applied last so an event
  // in the same cycle as a clear is never lost
  always_comb
  begin
    next_start_seen = synced[2];
    next_stop_seen = synced[3];
    // role: set on generated start, arbitration loss wins over it
    next_controller_role_flag = controller_role_flag;
    if (eng_start_gen_in)
      next_controller_role_flag = 1'h1;
    if (eng_stop_gen_in | arb_ev)
      next_controller_role_flag = 1'h0;
    // data written since the last frame start decides direction
    next_data_since_frame = data_since_frame;
    if (eng_frame_start_in)
      next_data_since_frame = 1'h0;
    if (data_written_in)
      next_data_since_frame = 1'h1;
    next_transmit_direction_flag = transmit_direction_flag;
    if (eng_frame_start_in)
      next_transmit_direction_flag = data_since_frame | data_written_in;
    if (start_det | arb_ev)
      next_transmit_direction_flag = 1'h0;
    if (eng_start_gen_in)
      next_transmit_direction_flag = 1'h1;
    // start request: software owns it, hardware can only set it
    next_start_request_flag = start_request_flag;
    if (wr_start)
      next_start_request_flag = bit_val(byte_wr, sfr_wdata_in,
        sfr_bit_val_in, `SMBCS_BIT_STARTREQ);
    if (eng_addr_rx_in)
      next_start_request_flag = 1'h1;
    // stop request: cleared once the engine has made the stop
    next_stop_request_flag = stop_request_flag;
    if (wr_stop)
      next_stop_request_flag = bit_val(byte_wr, sfr_wdata_in,
        sfr_bit_val_in, `SMBCS_BIT_STOPREQ);
    if (eng_stop_gen_in)
      next_stop_request_flag = 1'h0;
    if ((stop_det & eng_addressed_in) | arb_stop)
      next_stop_request_flag = 1'h1;
    // ack needed: only without automatic acknowledge
    next_ack_needed_flag = ack_needed_flag;
    if (eng_ack_done_in)
      next_ack_needed_flag = 1'h0;
    if (eng_byte_rx_in & !auto_address_response_enable_in)
      next_ack_needed_flag = 1'h1;
    // arbitration loss follows the event flag's software clear
    next_arbitration_loss_flag = arbitration_loss_flag;
    if (si_clear_ev)
      next_arbitration_loss_flag = 1'h0;
    if (arb_ev)
      next_arbitration_loss_flag = 1'h1;
    // acknowledge bit and whether software chose it for this byte
    next_ack_written = ack_written;
    if (eng_ack_done_in | eng_byte_rx_in)
      next_ack_written = 1'h0;
    if (wr_ack)
      next_ack_written = 1'h1;
    next_ack_value = ack_value;
    if (si_clear_ev & ack_needed_flag & !ack_written & !wr_ack)
      next_ack_value = 1'h0;
    if (wr_ack)
      next_ack_value = bit_val(byte_wr, sfr_wdata_in, sfr_bit_val_in,
        `SMBCS_BIT_ACK);
    if (eng_byte_tx_in)
      next_ack_value = !eng_ack_value_in;
    // event flag: software write first, hardware set wins
    next_event_pending_flag = event_pending_flag;
    if (wr_event)
      next_event_pending_flag = bit_val(byte_wr, sfr_wdata_in,
        sfr_bit_val_in, `SMBCS_BIT_EVENT);
    if (si_set)
      next_event_pending_flag = 1'h1;
    // read data registered every cycle from the current bits
    next_rdata = (sfr_addr_in == `SMBCS_CTRL_ADDR) &&
      (sfr_page_in == `SMBCS_CTRL_PAGE) ? reg_view : `SMBCS_RESET_VAL;
  end

  ////////////////////////////////////////////////////////////////////////
  // registers only; clock enable low freezes everything
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      controller_role_flag <= 1'h0;
      transmit_direction_flag <= 1'h0;
      start_request_flag <= 1'h0;
      stop_request_flag <= 1'h0;
      ack_needed_flag <= 1'h0;
      arbitration_loss_flag <= 1'h0;
      ack_value <= 1'h0;
      event_pending_flag <= 1'h0;
      ack_written <= 1'h0;
      data_since_frame <= 1'h0;
      start_seen <= 1'h0;
      stop_seen <= 1'h0;
      rdata <= `SMBCS_RESET_VAL;
    end
    else if (ce_in)
    begin
      controller_role_flag <= next_controller_role_flag;
      transmit_direction_flag <= next_transmit_direction_flag;
      start_request_flag <= next_start_request_flag;
      stop_request_flag <= next_stop_request_flag;
      ack_needed_flag <= next_ack_needed_flag;
      arbitration_loss_flag <= next_arbitration_loss_flag;
      ack_value <= next_ack_value;
      event_pending_flag <= next_event_pending_flag;
      ack_written <= next_ack_written;
      data_since_frame <= next_data_since_frame;
      start_seen <= next_start_seen;
      stop_seen <= next_stop_seen;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register layout as software sees it
  always_comb
  begin
    reg_view = `SMBCS_RESET_VAL;
    reg_view[`SMBCS_BIT_ROLE] = controller_role_flag;
    reg_view[`SMBCS_BIT_TXDIR] = transmit_direction_flag;
    reg_view[`SMBCS_BIT_STARTREQ] = start_request_flag;
    reg_view[`SMBCS_BIT_STOPREQ] = stop_request_flag;
    reg_view[`SMBCS_BIT_ACKNEED] = ack_needed_flag;
    reg_view[`SMBCS_BIT_ARBLOSS] = arbitration_loss_flag;
    reg_view[`SMBCS_BIT_ACK] = ack_value;
    reg_view[`SMBCS_BIT_EVENT] = event_pending_flag;
  end

  // outputs; the clock line is only ever pulled low, never driven high
  assign sfr_rdata_out = rdata;
  assign scl_out = 1'h0;
  assign scl_oe_out = event_pending_flag;
  assign sda_out = 1'h0;
  // the ack bit is sent in both software and automatic modes
  assign sda_oe_out = eng_ack_slot_in & ack_value;
  // a pending stop holds the start back until the stop is made
  assign gen_start_out = start_request_flag &
    !(controller_role_flag & stop_request_flag);
  assign gen_stop_out = controller_role_flag & stop_request_flag;
  assign next_event_out = si_clear_ev & ce_in;
  assign controller_role_out = controller_role_flag;
  assign transmit_direction_out = transmit_direction_flag;

  ////////////////////////////////////////////////////////////////////////
  // checks of flag behaviour against their causes
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_ack_owed;
    ce_in && si_clear_ev && ack_needed_flag && !ack_written && !wr_ack &&
      !eng_byte_tx_in;
  endsequence

  sequence s_arb_hit;
    ce_in && arb_ev;
  endsequence

  sequence s_sw_release;
    ce_in && si_clear_ev && !arb_ev;
  endsequence

  role_set_a: assert property (ce_in && eng_start_gen_in && !arb_ev &&
    !eng_stop_gen_in |=> controller_role_out)
    else $error("role not set after generated start");

  role_clr_a: assert property (s_arb_hit |=> !controller_role_flag &&
    arbitration_loss_flag)
    else $error("arbitration loss not recorded");

  arb_clear_a: assert property (s_sw_release |=> !arbitration_loss_flag &&
    (!event_pending_flag || $past(si_set)))
    else $error("arbitration flag survived event clear");

  nack_default_a: assert property (s_ack_owed |=> !ack_value)
    else $error("unwritten ack did not default to nack");

  start_hold_a: assert property (ce_in && start_request_flag && !wr_start
    |=> start_request_flag)
    else $error("start request cleared by hardware");

  stop_done_a: assert property (ce_in && eng_stop_gen_in && !wr_stop &&
    !stop_det |=> !stop_request_flag)
    else $error("stop request not cleared after stop");

  ack_need_a: assert property (ce_in && eng_byte_rx_in &&
    !auto_address_response_enable_in |=> ack_needed_flag ##1
    (ack_needed_flag || $past(eng_ack_done_in)))
    else $error("ack needed flag not raised");

  stall_low_a: assert property (event_pending_flag |-> scl_oe_out &&
    !scl_out && !next_event_out || si_clear_ev)
    else $error("clock line released while event pending");

  ack_rx_a: assert property (ce_in && eng_byte_tx_in |=>
    ack_value == !$past(eng_ack_value_in))
    else $error("received ack not reflected");

  ro_bits_a: assert property (ce_in && byte_wr && !eng_start_gen_in &&
    !eng_stop_gen_in && !arb_ev |=> $stable(controller_role_flag))
    else $error("read-only role bit changed by write");

  event_set_a: assert property (ce_in && si_set |=> event_pending_flag ##1
    (event_pending_flag || $past(si_clear_ev)))
    else $error("event flag not set by bus event");

  stop_first_a: assert property (controller_role_flag && stop_request_flag
    |-> !gen_start_out)
    else $error("start requested ahead of pending stop");

endmodule

`default_nettype wire

// >>> hw/smbcs_link_det.sv
// bus condition detector clocked by the link oversampling clock
// assumes the link clock runs free and is several times the bit rate
`timescale 1ns/1ps
`default_nettype none
`include "smbcs_consts.svh"

module smbcs_link_det
(
  input wire logic link_clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic start_tgl_out,
  output logic stop_tgl_out
);

  logic [`SMBCS_LINK_SYNC_W-1:0] pins;
  logic sda_prev;
  logic start_tgl;
  logic stop_tgl;
  logic next_sda_prev;
  logic next_start_tgl;
  logic next_stop_tgl;

  ////////////////////////////////////////////////////////////////////////
  // pins pass two flops on the link clock before any detection; they
  // enter inverted so the flops' zero reset level matches idle-high lines
  // and no false stop is seen as the chain fills after reset
  smbcs_sync #(.W(`SMBCS_LINK_SYNC_W)) u_pin_sync
  (
    .clk_in(link_clk_in),
    .rst_in(rst_in),
    .en_in(1'h1),
    .d_in({!scl_in, !sda_in}),
    .q_out(pins)
  );

  ////////////////////////////////////////////////////////////////////////
  // data edge with clock high is a start (fall) or a stop (rise);
  // toggles, not pulses, so the slower-edge-count core never misses one
  always_comb
  begin
    next_sda_prev = !pins[0];
    next_start_tgl = start_tgl ^ (!pins[1] & sda_prev & pins[0]);
    next_stop_tgl = stop_tgl ^ (!pins[1] & !sda_prev & !pins[0]);
  end

  // registers only; data idles high
  always_ff @(posedge link_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sda_prev <= 1'h1;
      start_tgl <= 1'h0;
      stop_tgl <= 1'h0;
    end
    else
    begin
      sda_prev <= next_sda_prev;
      start_tgl <= next_start_tgl;
      stop_tgl <= next_stop_tgl;
    end
  end

  assign start_tgl_out = start_tgl;
  assign stop_tgl_out = stop_tgl;

endmodule

`default_nettype wire

// >>> hw/smbcs_pkg.sv
// shared types of the serial bus control/status register block
// assumes nothing beyond a SystemVerilog compiler
package smbcs_pkg;

  // one register or data byte
  typedef logic [7:0] smbcs_byte_t;
  // index of a bit inside the register
  typedef logic [2:0] smbcs_bit_idx_t;

endpackage

// >>> hw/smbcs_sync.sv
// multi-bit two flip-flop synchroniser for levels and toggles
// assumes every bit changes independently of the others
`timescale 1ns/1ps
`default_nettype none

module smbcs_sync
#(
  parameter int W = 2
)
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  ////////////////////////////////////////////////////////////////////////
  // one independent two-stage chain per bit; first stage read only by second
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      logic meta;
      logic stable;
      logic next_meta;
      logic next_stable;

      // next values, frozen while the enable is low
      always_comb
      begin
        next_meta = en_in ? d_in[gi] : meta;
        next_stable = en_in ? meta : stable;
      end

      // registers only
      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          meta <= 1'h0;
          stable <= 1'h0;
        end
        else
        begin
          meta <= next_meta;
          stable <= next_stable;
        end
      end

      assign q_out[gi] = stable;
    end
  endgenerate

endmodule

`default_nettype wire

// >>> verif/smbcs_partner.sv
// far-side device on the two bus wires, behind pull-ups
// assumes the bench calls its tasks; both lines are wired-and
`timescale 1ns/1ps
`default_nettype none
module smbcs_partner
(
  input wire logic scl_oe_in,
  input wire logic sda_oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic scl_pull = 1'b0;
  logic sda_pull = 1'b0;
  // released lines float high; either party may pull low
  assign scl_out = !(scl_pull | scl_oe_in);
  assign sda_out = !(sda_pull | sda_oe_in);
  // data edge with clock high: fall is start, rise is stop
  task automatic cond(input logic stop);
    sda_pull = stop;
    #600;
    sda_pull = !stop;
    #600;
  endtask
  // data changed under a low clock so no condition is seen
  task automatic data_low(input logic low);
    scl_pull = 1'b1;
    #300;
    sda_pull = low;
    #300;
    scl_pull = 1'b0;
    #300;
  endtask
  // clock line stretched low or let go, as a slow device would
  task automatic clk_low(input logic low);
    scl_pull = low;
    #300;
  endtask
endmodule
`default_nettype wire

// >>> verif/tb.sv
// self-checking bench of the control/status register block
// assumes the partner on the pins; the bench acts as byte engine
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic link_clk = 1'b0;
  logic wr = 1'b0;
  logic bwr = 1'b0;
  logic bval = 1'b0;
  logic slot = 1'b0;
  logic ack_v = 1'b0;
  logic adr = 1'b0;
  logic tx_lvl = 1'b0;
  logic auto_ack = 1'b0;
  logic nx = 1'b0;
  logic ce = 1'b1;
  logic gcond = 1'b0;
  logic [7:0] addr = 8'hC0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] baddr = 8'h00;
  logic [8:0] ev_p = 9'h000;
  logic [7:0] rdata;
  logic scl, sda, scl_oe, sda_oe, g_st, g_sp, nxt, role, txdir;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  //////////////////////////////////////////////////////////////////////
  // engine pulses: 0 start 1 stop 2 tx 3 rx 4 addr 5 ackdone 6 txbit
  smbcs_ctrl DUT
  (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
    .link_clk_in(link_clk), .sfr_page_in(8'h00),
    .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_wdata_in(wdata),
    .sfr_bit_wr_in(bwr), .sfr_bit_addr_in(baddr),
    .sfr_bit_val_in(bval), .sfr_rdata_out(rdata),
    .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe_out(sda_oe),
    .eng_start_gen_in(ev_p[0]), .eng_stop_gen_in(ev_p[1]),
    .eng_byte_tx_in(ev_p[2]), .eng_ack_value_in(ack_v),
    .eng_byte_rx_in(ev_p[3]), .eng_addr_rx_in(ev_p[4]),
    .eng_addressed_in(adr), .eng_ack_slot_in(slot),
    .eng_ack_done_in(ev_p[5]), .eng_tx_bit_in(ev_p[6]),
    .eng_tx_level_in(tx_lvl), .eng_tx_is_ack_in(1'b0),
    .eng_gen_cond_in(gcond), .eng_frame_start_in(ev_p[7]),
    .data_written_in(ev_p[8]),
    .auto_address_response_enable_in(auto_ack),
    .gen_start_out(g_st), .gen_stop_out(g_sp),
    .next_event_out(nxt), .controller_role_out(role),
    .transmit_direction_out(txdir)
  );
  smbcs_partner bus
  (
    .scl_oe_in(scl_oe), .sda_oe_in(sda_oe),
    .scl_out(scl), .sda_out(sda)
  );
  //////////////////////////////////////////////////////////////////////
  // core clock; link clock rises once inside reset, then 125 ns period
  always #4 clk_in = !clk_in;
  initial
  begin
    #3;
    forever
    begin
      link_clk = !link_clk;
      #62.5;
    end
  end
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      stop_test();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t byte %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk_in) #1;
  endtask
  // next_event is combinational, so it is caught while the strobe is up
  task automatic wbyte(input logic [7:0] d);
    tick();
    wdata = d;
    wr = 1'b1;
    #2 nx = nxt;
    tick();
    wr = 1'b0;
  endtask
  task automatic bwrite(input logic [2:0] i, input logic v);
    tick();
    baddr = {5'h18, i};
    bval = v;
    bwr = 1'b1;
    #2 nx = nxt;
    tick();
    bwr = 1'b0;
  endtask
  task automatic ev(input int k);
    tick();
    ev_p[k] = 1'b1;
    tick();
    ev_p = 9'h000;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk8(rdata, 8'h00);
    chk1(scl_oe, 1'b0);
    addr = 8'hC1;
    wbyte(8'h20);
    tick();
    chk8(rdata, 8'h00);
    addr = 8'hC0;
    tick();
    chk8(rdata, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_master;
    wbyte(8'h20);
    chk1(g_st, 1'b1);
    ev(0);
    chk1(scl_oe, 1'b1);
    tick();
    chk8(rdata, 8'hE1);
    wbyte(8'h31);
    tick();
    chk8(rdata, 8'hF1);
    chk1(g_sp & !g_st, 1'b1);
    wbyte(8'h30);
    chk1(nx, 1'b1);
    ev(1);
    tick();
    chk8(rdata, 8'h60);
    chk1(g_st, 1'b1);
    wbyte(8'h00);
    $display("master test done");
  endtask
  task automatic t_rx;
    ev(3);
    chk1(scl_oe, 1'b1);
    tick();
    chk1(rdata[3], 1'b1);
    bwrite(1, 1'b1);
    slot = 1'b1;
    tick();
    chk1(sda_oe, 1'b1);
    slot = 1'b0;
    bwrite(0, 1'b0);
    chk1(nx, 1'b1);
    ev(5);
    tick();
    chk8(rdata & 8'h09, 8'h00);
    ev(3);
    bwrite(0, 1'b0);
    slot = 1'b1;
    tick();
    chk1(sda_oe, 1'b0);
    slot = 1'b0;
    ev(5);
    auto_ack = 1'b1;
    ev(3);
    tick();
    chk1(rdata[3], 1'b0);
    bwrite(0, 1'b0);
    auto_ack = 1'b0;
    $display("receive test done");
  endtask
  task automatic t_txack;
    ev(2);
    tick();
    chk8(rdata & 8'h03, 8'h03);
    bwrite(0, 1'b0);
    ack_v = 1'b1;
    ev(2);
    ack_v = 1'b0;
    tick();
    chk8(rdata & 8'h03, 8'h01);
    bwrite(0, 1'b0);
    $display("transmit ack test done");
  endtask
  task automatic t_arb;
    wbyte(8'h20);
    ev(0);
    wbyte(8'h20);
    bus.data_low(1'b1);
    tx_lvl = 1'b1;
    ev(6);
    tx_lvl = 1'b0;
    tick();
    chk8(rdata & 8'h85, 8'h05);
    bus.data_low(1'b0);
    wbyte(8'h00);
    tick();
    chk1(rdata[2], 1'b0);
    bwrite(0, 1'b1);
    tick();
    chk1(rdata[0] & scl_oe, 1'b1);
    bwrite(0, 1'b0);
    $display("arbitration test done");
  endtask
  task automatic t_pins;
    wbyte(8'h20);
    ev(0);
    wbyte(8'h00);
    bus.cond(1'b0);
    repeat (20) tick();
    chk8(rdata & 8'hC5, 8'h05);
    wbyte(8'h00);
    adr = 1'b1;
    bus.cond(1'b1);
    repeat (20) tick();
    chk8(rdata & 8'h11, 8'h11);
    adr = 1'b0;
    ev(4);
    tick();
    chk1(rdata[5], 1'b1);
    wbyte(8'h00);
    tick();
    chk8(rdata, 8'h00);
    $display("pin test done");
  endtask
  // clock low while making a condition, then a frozen clock enable
  task automatic t_cond;
    wbyte(8'h20);
    ev(0);
    chk1(role & txdir, 1'b1);
    wbyte(8'h20);
    bus.clk_low(1'b1);
    tick();
    gcond = 1'b1;
    tick();
    gcond = 1'b0;
    bus.clk_low(1'b0);
    tick();
    chk8(rdata & 8'hC5, 8'h05);
    chk1(role | txdir, 1'b0);
    ce = 1'b0;
    wbyte(8'h00);
    chk1(nx, 1'b0);
    ce = 1'b1;
    tick();
    chk8(rdata & 8'h05, 8'h05);
    wbyte(8'h00);
    chk1(nx, 1'b1);
    $display("condition and enable test done");
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // reset for six cycles, then the scenarios in turn
  initial
  begin
    repeat (6) @(posedge clk_in);
    #1 rst_in = 1'b0;
    t_reset();
    t_master();
    t_rx();
    t_txack();
    t_arb();
    t_pins();
    t_cond();
    stop_test();
  end
endmodule
`default_nettype wire
